//--- hdl/bsw_flag_word.sv
// Overview of operation
// - Low-charge and low-runtime alarms use current or power per energy_units_select.
// - Alarm broadcast word equals status word with error-code bits all ones.
// - Error code 0 after a command processed without error.
// - Error code 1 when a command cannot be processed now.
// - Error code 2 on reserved or unsupported manufacturer command access.
// - Error code 3 for a defined but unsupported command.
// - Error code 4 on write to a read-only command.
// - Error code 5 on overflow or underflow, 7 on unidentified error.
// - Error code 6 on write with wrong data block size.
// - Overcharge flag set while overcharging; cleared after 2 mAh without charging.
// - Stop-charge flag on bad parameter or termination; cleared when over or idle.
// - Hot flag while temperature at or above limit.
// - Stop-discharge flag on zero charge, cutoff voltage or cell undervoltage.
// - Low-charge flag below threshold; cleared above it or on charging rise.
// - Low-runtime flag below threshold; cleared above it or on charging rise.
// - Config-valid flag set on good flash load, cleared on bad load.
// - Not-charging flag set whenever battery is not charging.
// - Full flag on termination or overcharge; cleared below full-clear percent.
// - Empty flag on low voltage at light load or low percent; cleared at 20%.
// - Count charge cycles per quantum and save count after every update.
// - Cycle count reports 0..65534 directly, saturates at 65535.
// - Design capacity reported in mAh or 10 mWh per energy_units_select.
`timescale 1ns/1ns
`default_nettype none
`include "bsw_defs.svh"

module bsw_flag_word #(
  parameter logic [6:0] SLAVE_ADDR = 7'h0b
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic energy_units_select_i,
  input wire bsw_pkg::bsw_meas_t meas_i,
  input wire bsw_pkg::bsw_cond_t cond_i,
  input wire logic cfg_load_ok_i,
  input wire logic cfg_load_bad_i,
  input wire logic [15:0] restored_count_i,
  input wire logic relax_mah_tick_i,
  input wire logic dsg_mah_tick_i,
  input wire logic [15:0] cycle_charge_quantum_i,
  input wire logic [15:0] design_cap_mah_i,
  input wire logic [15:0] design_cap_10mwh_i,
  input wire logic ext_err_stb_i,
  input wire logic [2:0] ext_err_code_i,
  output logic [15:0] status_word_o,
  output logic [15:0] alarm_word_o,
  output logic [15:0] cycle_count_o,
  output logic nv_save_o,
  output logic [15:0] nv_count_o
);
  import bsw_pkg::*;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic [1:0] pins_q;
  logic sc;
  logic sd;

  bsw_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({scl_i, sda_i}),
    .q_o(pins_q)
  );

  assign sc = pins_q[1];
  assign sd = pins_q[0];

  // ****************************************************************
  // State
  // ****************************************************************
  bsw_state_t st;
  bsw_state_t next_st;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [15:0] sel_rem;
  logic [15:0] sel_rt;
  logic [15:0] sel_cap;
  logic cmd_mapped;
  logic [15:0] cmd_word;
  logic term_cond;
  logic empty_set;
  logic bus_err_ev;
  logic wr_data_ev;
  logic [15:0] status_w;

  assign scl_rise = sc & ~st.pscl;
  assign scl_fall = ~sc & st.pscl;
  assign start_ev = sc & st.pscl & st.psda & ~sd;
  assign stop_ev = sc & st.pscl & ~st.psda & sd;

  always_comb begin
    sel_rem = energy_units_select_i ? meas_i.remaining_charge_pwr
                                    : meas_i.remaining_charge_cur;
    sel_rt = energy_units_select_i ? meas_i.runtime_pwr : meas_i.runtime_cur;
    sel_cap = energy_units_select_i ? design_cap_10mwh_i : design_cap_mah_i;
  end

  // ****************************************************************
  // Status word assembly
  // ****************************************************************
  always_comb begin
    status_w = '0;
    status_w[`BSW_B_OVCHG] = st.flags.ovchg;
    status_w[`BSW_B_STOPCHG] = st.flags.stopchg;
    status_w[`BSW_B_HOT] = st.flags.hot;
    status_w[`BSW_B_STOPDSG] = st.flags.stopdsg;
    status_w[`BSW_B_LOWCHG] = st.flags.lowchg;
    status_w[`BSW_B_LOWRT] = st.flags.lowrt;
    status_w[`BSW_B_CFG] = st.flags.cfg;
    status_w[`BSW_B_NOTCHG] = st.flags.notchg;
    status_w[`BSW_B_FULL] = st.flags.full;
    status_w[`BSW_B_EMPTY] = st.flags.empty;
    status_w[`BSW_ERR_MSB:`BSW_ERR_LSB] = st.err;
  end

  always_comb begin
    cmd_mapped = 1'b1;
    case (st.cmd)
      `BSW_CMD_FLAGS: cmd_word = status_w;
      `BSW_CMD_CYCLES: cmd_word = st.cycles;
      `BSW_CMD_DESIGN: cmd_word = sel_cap;
      default: begin
        cmd_word = `BSW_CYC_MAX;
        cmd_mapped = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.pscl = sc;
    next_st.psda = sd;
    next_st.nv_save = 1'b0;
    bus_err_ev = 1'b0;
    wr_data_ev = 1'b0;
    term_cond = cond_i.param_out_of_range | cond_i.primary_term;
    empty_set = (((meas_i.pack_voltage < meas_i.end_voltage_level2) ||
                  (meas_i.cell_voltage < meas_i.end_voltage_level2)) &&
                 (meas_i.current < meas_i.overload_current_setting)) ||
                (meas_i.relative_charge_percent < meas_i.low_percent_setting);

    // Read-word slave engine
    if (start_ev) begin
      next_st.bus = BS_RX;
      next_st.bits = '0;
      next_st.idx = '0;
      next_st.sda_oe = 1'b0;
    end else if (stop_ev) begin
      next_st.bus = BS_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.bus)
        BS_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        BS_RX: begin
          if (scl_rise && st.bits != `BSW_BYTE_BITS) begin
            next_st.shreg = {st.shreg[6:0], sd};
            next_st.bits = st.bits + 4'h1;
          end else if (scl_fall && st.bits == `BSW_BYTE_BITS) begin
            next_st.bits = '0;
            next_st.bus = BS_RACK;
            next_st.sda_oe = 1'b1;
            if (st.idx != `BSW_IDX_LAST) begin
              next_st.idx = st.idx + 2'h1;
            end
            if (st.idx == '0) begin
              next_st.rd = st.shreg[0];
              if (st.shreg[7:1] != SLAVE_ADDR) begin
                next_st.bus = BS_IDLE;
                next_st.sda_oe = 1'b0;
              end else if (st.shreg[0]) begin
                next_st.txw = cmd_word;
                bus_err_ev = 1'b1;
                next_st.err = cmd_mapped ? `BSW_ERR_OK : `BSW_ERR_RSVD;
              end
            end else if (st.idx == `BSW_IDX_CMD) begin
              next_st.cmd = st.shreg;
            end else if (st.idx == `BSW_IDX_DATA) begin
              wr_data_ev = 1'b1;
              bus_err_ev = 1'b1;
              next_st.err = cmd_mapped ? `BSW_ERR_DENIED : `BSW_ERR_RSVD;
            end
          end
        end
        BS_RACK: begin
          if (scl_fall) begin
            if (st.rd) begin
              next_st.bus = BS_TX;
              next_st.tx_hi = 1'b0;
              next_st.shreg = st.txw[7:0];
              next_st.sda_oe = ~st.txw[7];
            end else begin
              next_st.bus = BS_RX;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        BS_TX: begin
          if (scl_fall) begin
            if (st.bits == `BSW_LAST_BIT) begin
              next_st.bus = BS_TACK;
              next_st.sda_oe = 1'b0;
            end else begin
              next_st.bits = st.bits + 4'h1;
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_oe = ~st.shreg[6];
            end
          end
        end
        BS_TACK: begin
          if (scl_rise) begin
            if (sd || st.tx_hi) begin
              next_st.bus = BS_IDLE;
            end else begin
              next_st.bits = `BSW_BYTE_BITS;
            end
          end else if (scl_fall && st.bits == `BSW_BYTE_BITS) begin
            next_st.bus = BS_TX;
            next_st.tx_hi = 1'b1;
            next_st.bits = '0;
            next_st.shreg = st.txw[15:8];
            next_st.sda_oe = ~st.txw[15];
          end
        end
        default: begin
          next_st.bus = BS_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end

    // Codes reported by the command processor; bus events take precedence
    if (ext_err_stb_i && !bus_err_ev) begin
      next_st.err = ext_err_code_i;
    end

    // Overcharge and its 2 mAh release
    next_st.ovclr = '0;
    if (cond_i.overcharge) begin
      next_st.flags.ovchg = 1'b1;
    end else if (st.flags.ovchg && !cond_i.charging) begin
      next_st.ovclr = st.ovclr;
      if (relax_mah_tick_i) begin
        if (st.ovclr + 2'h1 >= `BSW_OVCHG_CLR_MAH) begin
          next_st.flags.ovchg = 1'b0;
        end else begin
          next_st.ovclr = st.ovclr + 2'h1;
        end
      end
    end

    next_st.term_prev = term_cond;
    if (term_cond && !st.term_prev) begin
      next_st.flags.stopchg = 1'b1;
    end else if (!term_cond || !cond_i.charging) begin
      next_st.flags.stopchg = 1'b0;
    end

    next_st.flags.hot = meas_i.temperature >= meas_i.temp_limit_setting;
    next_st.flags.stopdsg = (sel_rem == '0) ||
                            (meas_i.pack_voltage <= meas_i.cutoff_voltage_setting) ||
                            cond_i.cell_undervoltage_flag;

    next_st.rem_prev = sel_rem;
    if (sel_rem < meas_i.low_charge_threshold) begin
      next_st.flags.lowchg = 1'b1;
    end else if (meas_i.low_charge_threshold < sel_rem ||
                 (cond_i.charging && sel_rem > st.rem_prev)) begin
      next_st.flags.lowchg = 1'b0;
    end

    next_st.rt_prev = sel_rt;
    if (sel_rt < meas_i.low_runtime_threshold) begin
      next_st.flags.lowrt = 1'b1;
    end else if (meas_i.low_runtime_threshold < sel_rt ||
                 (cond_i.charging && sel_rt > st.rt_prev)) begin
      next_st.flags.lowrt = 1'b0;
    end

    if (cfg_load_ok_i) begin
      next_st.flags.cfg = 1'b1;
    end else if (cfg_load_bad_i) begin
      next_st.flags.cfg = 1'b0;
    end

    next_st.flags.notchg = ~cond_i.charging;

    if (cond_i.primary_term || cond_i.overcharge) begin
      next_st.flags.full = 1'b1;
    end else if (meas_i.relative_charge_percent < meas_i.full_clear_percent) begin
      next_st.flags.full = 1'b0;
    end

    if (empty_set) begin
      next_st.flags.empty = 1'b1;
    end else if (meas_i.relative_charge_percent >= `BSW_EMPTY_CLR_PCT) begin
      next_st.flags.empty = 1'b0;
    end

    // Cycle counting with saturation and save after each update
    if (cfg_load_ok_i) begin
      next_st.cycles = restored_count_i;
    end else if (dsg_mah_tick_i) begin
      if (st.qacc + 16'h1 >= cycle_charge_quantum_i) begin
        next_st.qacc = '0;
        if (st.cycles != `BSW_CYC_MAX) begin
          next_st.cycles = st.cycles + 16'h1;
          next_st.nv_save = 1'b1;
        end
      end else begin
        next_st.qacc = st.qacc + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '{bus: BS_IDLE, pscl: 1'b1, psda: 1'b1, bits: 4'h0, shreg: 8'h00,
              idx: 2'h0, rd: 1'b0, cmd: 8'h00, txw: 16'h0000, tx_hi: 1'b0,
              sda_oe: 1'b0, flags: '0, err: `BSW_ERR_OK, ovclr: 2'h0,
              rem_prev: 16'h0000, rt_prev: 16'h0000, term_prev: 1'b0,
              qacc: 16'h0000, cycles: 16'h0000, nv_save: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o = 1'b0;
  assign sda_oe_o = st.sda_oe;
  assign status_word_o = status_w;
  assign alarm_word_o = {status_w[15:3], `BSW_ERR_UNKNOWN};
  assign cycle_count_o = st.cycles;
  assign nv_save_o = st.nv_save;
  assign nv_count_o = st.cycles;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_rd_ack;
    st.bus == BS_RACK && st.rd && scl_fall && !start_ev && !stop_ev;
  endsequence

  sequence s_wr_data;
    st.bus == BS_RX && st.idx == `BSW_IDX_DATA && scl_fall &&
    st.bits == `BSW_BYTE_BITS && !start_ev && !stop_ev;
  endsequence

  lsb_first_a: assert property (s_rd_ack |=> st.shreg == st.txw[7:0] && !st.tx_hi)
    else $error("first byte sent is not the low byte");

  ro_denied_a: assert property (s_wr_data ##0 (wr_data_ev && cmd_mapped) |=> st.err == `BSW_ERR_DENIED)
    else $error("write to read-only word not denied");

  alarm_word_a: assert property (alarm_word_o[2:0] == `BSW_ERR_UNKNOWN &&
                                 alarm_word_o[15:3] == status_word_o[15:3])
    else $error("alarm word differs from status word");

  rsvd_zero_a: assert property (status_word_o[`BSW_B_RSVD_HI] == 1'b0 &&
                                status_word_o[`BSW_B_RSVD_MID] == 1'b0 &&
                                status_word_o[`BSW_B_RSVD_LO] == 1'b0)
    else $error("reserved status bit set");

  hot_track_a: assert property (meas_i.temperature >= meas_i.temp_limit_setting
                                |=> status_word_o[`BSW_B_HOT])
    else $error("hot flag missed");

  stop_dsg_a: assert property (cond_i.cell_undervoltage_flag |=> st.flags.stopdsg)
    else $error("stop-discharge flag missed");

  cyc_sat_a: assert property (st.cycles == `BSW_CYC_MAX && !cfg_load_ok_i
                              |=> st.cycles == `BSW_CYC_MAX && !nv_save_o)
    else $error("cycle count left saturation");

  nv_save_a: assert property (dsg_mah_tick_i && !cfg_load_ok_i &&
                              st.qacc + 16'h1 >= cycle_charge_quantum_i &&
                              st.cycles != `BSW_CYC_MAX
                              |=> nv_save_o && nv_count_o == $past(st.cycles) + 16'h1)
    else $error("cycle update not saved");

  ovchg_clr_a: assert property ($fell(st.flags.ovchg) |-> $past(relax_mah_tick_i) &&
                                !$past(cond_i.charging))
    else $error("overcharge flag cleared without discharge");

  empty_clr_a: assert property (!empty_set &&
                                meas_i.relative_charge_percent >= `BSW_EMPTY_CLR_PCT
                                |=> !st.flags.empty)
    else $error("empty flag not cleared at 20 percent");

endmodule

`default_nettype wire

//--- hdl/bsw_defs.svh
`ifndef BSW_DEFS_SVH
`define BSW_DEFS_SVH

// ****************************************************************
// Command codes of the words this block answers
// ****************************************************************
`define BSW_CMD_FLAGS 8'h16
`define BSW_CMD_CYCLES 8'h17
`define BSW_CMD_DESIGN 8'h18

// ****************************************************************
// Status word bit positions
// ****************************************************************
`define BSW_B_OVCHG 15
`define BSW_B_STOPCHG 14
`define BSW_B_RSVD_HI 13
`define BSW_B_HOT 12
`define BSW_B_STOPDSG 11
`define BSW_B_RSVD_MID 10
`define BSW_B_LOWCHG 9
`define BSW_B_LOWRT 8
`define BSW_B_CFG 7
`define BSW_B_NOTCHG 6
`define BSW_B_FULL 5
`define BSW_B_EMPTY 4
`define BSW_B_RSVD_LO 3
`define BSW_ERR_MSB 2
`define BSW_ERR_LSB 0

// ****************************************************************
// Error codes
// ****************************************************************
`define BSW_ERR_OK 3'h0
`define BSW_ERR_BUSY 3'h1
`define BSW_ERR_RSVD 3'h2
`define BSW_ERR_UNSUP 3'h3
`define BSW_ERR_DENIED 3'h4
`define BSW_ERR_OVFL 3'h5
`define BSW_ERR_SIZE 3'h6
`define BSW_ERR_UNKNOWN 3'h7

// ****************************************************************
// Counts and limits
// ****************************************************************
`define BSW_OVCHG_CLR_MAH 2'h2
`define BSW_EMPTY_CLR_PCT 8'h14
`define BSW_CYC_MAX 16'hffff
`define BSW_BYTE_BITS 4'h8
`define BSW_LAST_BIT 4'h7
`define BSW_IDX_LAST 2'h3
`define BSW_IDX_CMD 2'h1
`define BSW_IDX_DATA 2'h2

`endif

//--- hdl/bsw_pkg.sv
package bsw_pkg;

  // Measurements and settings from the gauge core, same clock
  typedef struct packed {
    logic [15:0] remaining_charge_cur;
    logic [15:0] remaining_charge_pwr;
    logic [15:0] runtime_cur;
    logic [15:0] runtime_pwr;
    logic [15:0] low_charge_threshold;
    logic [15:0] low_runtime_threshold;
    logic [7:0] relative_charge_percent;
    logic [15:0] temperature;
    logic [15:0] temp_limit_setting;
    logic [15:0] pack_voltage;
    logic [15:0] cutoff_voltage_setting;
    logic [15:0] cell_voltage;
    logic [15:0] end_voltage_level2;
    logic [15:0] current;
    logic [15:0] overload_current_setting;
    logic [7:0] low_percent_setting;
    logic [7:0] full_clear_percent;
  } bsw_meas_t;

  // Charge state conditions, levels
  typedef struct packed {
    logic charging;
    logic overcharge;
    logic param_out_of_range;
    logic primary_term;
    logic cell_undervoltage_flag;
  } bsw_cond_t;

  typedef struct packed {
    logic ovchg;
    logic stopchg;
    logic hot;
    logic stopdsg;
    logic lowchg;
    logic lowrt;
    logic cfg;
    logic notchg;
    logic full;
    logic empty;
  } bsw_flags_t;

  typedef enum logic [2:0] {
    BS_IDLE,
    BS_RX,
    BS_RACK,
    BS_TX,
    BS_TACK
  } bsw_bus_st_t;

  typedef struct packed {
    bsw_bus_st_t bus;
    logic pscl;
    logic psda;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic [1:0] idx;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] txw;
    logic tx_hi;
    logic sda_oe;
    bsw_flags_t flags;
    logic [2:0] err;
    logic [1:0] ovclr;
    logic [15:0] rem_prev;
    logic [15:0] rt_prev;
    logic term_prev;
    logic [15:0] qacc;
    logic [15:0] cycles;
    logic nv_save;
  } bsw_state_t;

endpackage

//--- hdl/bsw_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for pin inputs
// ****************************************************************
module bsw_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } bsw_sync_st_t;

  bsw_sync_st_t st;
  bsw_sync_st_t next_st;

  always_comb begin
    next_st.meta = d_i;
    next_st.q = st.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.q;
endmodule

`default_nettype wire

//--- dv/bsw_host.sv
`timescale 1ns/1ns
`default_nettype none

// ********
// SMBus host model, open drain, SCL period 800 ns
// ********
module bsw_host (
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Data moves 420 ns after SCL falls so the device's hold window is kept
  task automatic bit_x(input logic b, output logic r);
    #420 sda_oe_o = !b;
    #130 scl_o = 1'b1;
    #240 r = sda_i;
    #10 scl_o = 1'b0;
  endtask

  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] r,
      output logic n);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a, n);
  endtask

  task automatic start_x;
    if (!scl_o) begin
      #420 sda_oe_o = 1'b0;
      #130 scl_o = 1'b1;
    end
    #300 sda_oe_o = 1'b1;
    #300 scl_o = 1'b0;
  endtask

  task automatic stop_x;
    #420 sda_oe_o = 1'b1;
    #130 scl_o = 1'b1;
    #300 sda_oe_o = 1'b0;
    #400;
  endtask

  // Low byte acked by the host, high byte nacked
  task automatic rd_word(input logic [6:0] adr, input logic [7:0] cmd,
      output logic [15:0] w, output logic nak);
    logic [7:0] j;
    logic n0, n1, n2, n3;
    start_x();
    byte_x({adr, 1'h0}, 1'h1, j, n0);
    byte_x(cmd, 1'h1, j, n1);
    start_x();
    byte_x({adr, 1'h1}, 1'h1, j, n2);
    byte_x(8'hff, 1'h0, w[7:0], n3);
    byte_x(8'hff, 1'h1, w[15:8], n3);
    stop_x();
    nak = n0 | n1 | n2;
  endtask

  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic nak);
    logic [7:0] j;
    logic n0, n1;
    start_x();
    byte_x(8'h16, 1'h1, j, n0);
    byte_x(cmd, 1'h1, j, n1);
    byte_x(d[7:0], 1'h1, j, n1);
    byte_x(d[15:8], 1'h1, j, n1);
    stop_x();
    nak = n0;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_battery_status_flag_word.sv
`timescale 1ns/1ns
`default_nettype none

module tb_battery_status_flag_word;
  import bsw_pkg::*;
  typedef struct packed {
    logic eus;
    bsw_cond_t c;
    logic [7:0] rc, rp, tmp;
    logic [15:0] pv;
    logic [7:0] pct;
    logic [15:0] exp;
  } bsw_row_t;
  localparam bsw_row_t ROWS [20] = '{
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0040},
    '{1'h0, 5'h00, 8'h28, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0340},
    '{1'h1, 5'h00, 8'h28, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0040},
    '{1'h1, 5'h00, 8'h64, 8'h28, 8'ha, 16'h3e8, 8'h32, 16'h0340},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'h3c, 16'h3e8, 8'h32, 16'h1040},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'h3b, 16'h3e8, 8'h32, 16'h0040},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h1f4, 8'h32, 16'h0840},
    '{1'h0, 5'h00, 8'h00, 8'h00, 8'ha, 16'h3e8, 8'h32, 16'h0b40},
    '{1'h0, 5'h01, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0840},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h05, 16'h0050},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h13, 16'h0050},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h14, 16'h0040},
    '{1'h0, 5'h10, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0000},
    '{1'h0, 5'h14, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h4000},
    '{1'h0, 5'h10, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0000},
    '{1'h0, 5'h12, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h4020},
    '{1'h0, 5'h02, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0060},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h0040},
    '{1'h0, 5'h18, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h8020},
    '{1'h0, 5'h00, 8'h64, 8'h64, 8'ha, 16'h3e8, 8'h32, 16'h8040}
  };
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic eus = 1'h0;
  logic ok_p = 1'h0;
  logic bad_p = 1'h0;
  logic relax_p = 1'h0;
  logic dsg_p = 1'h0;
  logic estb = 1'h0;
  logic [2:0] ecode = 3'h0;
  logic scl, host_oe, sda_o, sda_oe, nv_save, nak;
  logic [15:0] status, alarm, cycles, nv_count, w;
  bsw_meas_t m;
  bsw_cond_t c;
  int failures = 0;
  int cmp_count = 0;
  int saves = 0;
  wire logic sda = !host_oe && (!sda_oe || sda_o);

  bsw_flag_word i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .energy_units_select_i(eus), .meas_i(m),
    .cond_i(c), .cfg_load_ok_i(ok_p), .cfg_load_bad_i(bad_p),
    .restored_count_i(16'hfffd), .relax_mah_tick_i(relax_p), .dsg_mah_tick_i(dsg_p),
    .cycle_charge_quantum_i(16'h2), .design_cap_mah_i(16'h1234),
    .design_cap_10mwh_i(16'h5678), .ext_err_stb_i(estb), .ext_err_code_i(ecode),
    .status_word_o(status), .alarm_word_o(alarm), .cycle_count_o(cycles),
    .nv_save_o(nv_save), .nv_count_o(nv_count));
  bsw_host i_host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));

  initial begin
    forever #50 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    saves <= saves + ((nv_save === 1'h1) ? 1 : 0);
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input logic [2:0] err);
    i_host.rd_word(7'h0b, cmd, w, nak);
    step(2);
    check(w, exp);
    check({12'h0, nak, status[2:0]}, {13'h0, err});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    finish_test();
  end

  initial begin
    m = '0;
    m.low_charge_threshold = 16'h32;
    m.low_runtime_threshold = 16'h32;
    m.temp_limit_setting = 16'h3c;
    m.cutoff_voltage_setting = 16'h1f4;
    m.cell_voltage = 16'h3e8;
    m.end_voltage_level2 = 16'h1f4;
    m.overload_current_setting = 16'h64;
    m.low_percent_setting = 8'ha;
    m.full_clear_percent = 8'h5a;
    c = '0;
    step(20);
    check(alarm, 16'h0007);
    check({15'h0, sda_oe}, 16'h0);
    nrst_i = 1'h1;
    step(3);
    ok_p = 1'h1;
    step(1);
    ok_p = 1'h0;
    step(2);
    check(cycles, 16'hfffd);
    foreach (ROWS[i]) begin
      eus = ROWS[i].eus;
      c = ROWS[i].c;
      m.remaining_charge_cur = {8'h0, ROWS[i].rc};
      m.runtime_cur = {8'h0, ROWS[i].rc};
      m.remaining_charge_pwr = {8'h0, ROWS[i].rp};
      m.runtime_pwr = {8'h0, ROWS[i].rp};
      m.temperature = {8'h0, ROWS[i].tmp};
      m.pack_voltage = ROWS[i].pv;
      m.relative_charge_percent = ROWS[i].pct;
      step(3);
      check(status, ROWS[i].exp | 16'h0080);
      check(alarm, ROWS[i].exp | 16'h0087);
    end
    for (int k = 0; k < 2; k++) begin
      relax_p = 1'h1;
      step(1);
      relax_p = 1'h0;
      step(2);
      check(status, (k == 0) ? 16'h80c0 : 16'h00c0);
    end
    for (int k = 0; k < 3; k++) begin
      repeat (2) begin
        dsg_p = 1'h1;
        step(1);
        dsg_p = 1'h0;
        step(1);
      end
      step(2);
      check(cycles, (k == 0) ? 16'hfffe : 16'hffff);
      check(nv_count, (k == 0) ? 16'hfffe : 16'hffff);
      check(16'(saves), (k == 0) ? 16'h1 : 16'h2);
    end
    for (int k = 1; k < 8; k++) begin
      ecode = 3'(k);
      estb = 1'h1;
      step(1);
      estb = 1'h0;
      step(1);
      check(status, 16'h00c0 | 16'(k));
    end
    rd(8'h16, 16'h00c7, 3'h0);
    rd(8'h17, 16'hffff, 3'h0);
    rd(8'h18, 16'h1234, 3'h0);
    eus = 1'h1;
    rd(8'h18, 16'h5678, 3'h0);
    rd(8'h30, 16'hffff, 3'h2);
    i_host.wr_word(8'h16, 16'h1234, nak);
    step(2);
    check(status, 16'h00c4);
    i_host.rd_word(7'h0c, 8'h16, w, nak);
    step(2);
    check({15'h0, nak}, 16'h1);
    bad_p = 1'h1;
    step(1);
    bad_p = 1'h0;
    step(2);
    check(status, 16'h0044);
    nrst_i = 1'h0;
    step(3);
    check(cycles, 16'h0000);
    check(status, 16'h0000);
    check({15'h0, sda_oe}, 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire
